// ==== rtl/pic_pkg.sv ====
// Constants, carrier types and decode helpers for the interrupt condition
// logic. Assumes an 8-bit control bus with a 6-bit register address.
package pic_pkg;

   // Register addresses on the control bus
   localparam logic [5:0] ADDR_CONFIG = 6'h01;
   localparam logic [5:0] ADDR_INT_COND = 6'h02;
   localparam logic [5:0] ADDR_INT_MASK = 6'h03;
   localparam logic [5:0] ADDR_XMIT = 6'h04;
   localparam logic [5:0] ADDR_RCV_A = 6'h09;
   localparam logic [5:0] ADDR_RCV_B = 6'h0a;
   localparam logic [5:0] ADDR_CMP_INT_COND = 6'h1a;
   localparam logic [5:0] ADDR_CMP_XMIT = 6'h1b;
   localparam logic [5:0] ADDR_CMP_RCV_A = 6'h1c;
   localparam logic [5:0] ADDR_CMP_RCV_B = 6'h1d;
   localparam logic [5:0] ADDR_CMP_CMT = 6'h1f;
   localparam logic [5:0] ADDR_CMT = 6'h20;

   // Interrupt condition bit positions
   localparam int unsigned BIT_DPE = 0;
   localparam int unsigned BIT_CPE = 1;
   localparam int unsigned BIT_CCR = 2;
   localparam int unsigned BIT_INHIBIT = 3;
   localparam int unsigned BIT_LINK_ERR = 4;
   localparam int unsigned BIT_RCV_A_SUM = 5;
   localparam int unsigned BIT_RCV_B_SUM = 6;
   localparam int unsigned BIT_USER_SUM = 7;

   // Reset values
   localparam logic [4:0] INT_COND_LOW_RESET = 5'h10;
   localparam logic [7:0] INT_MASK_RESET = 8'h00;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] LEM_COUNT_RESET = 8'h00;

   // Index of each conditionally written register and its compare copy
   localparam int unsigned CMP_DEPTH = 5;
   localparam logic [2:0] IDX_INT_COND = 3'h0;
   localparam logic [2:0] IDX_XMIT = 3'h1;
   localparam logic [2:0] IDX_RCV_A = 3'h2;
   localparam logic [2:0] IDX_RCV_B = 3'h3;
   localparam logic [2:0] IDX_CMT = 3'h4;
   localparam logic [2:0] IDX_NONE = 3'h7;

   typedef struct packed {
      logic we;
      logic [5:0] addr;
      logic [7:0] wdata;
   } pic_cb_req_t;

   typedef struct packed {
      logic valid;
      logic [2:0] target;
      logic [7:0] data;
   } pic_cond_wr_t;

   function automatic logic [2:0] pic_cmp_index(input logic [5:0] addr);
      case (addr)
         ADDR_CMP_INT_COND: pic_cmp_index = IDX_INT_COND;
         ADDR_CMP_XMIT: pic_cmp_index = IDX_XMIT;
         ADDR_CMP_RCV_A: pic_cmp_index = IDX_RCV_A;
         ADDR_CMP_RCV_B: pic_cmp_index = IDX_RCV_B;
         ADDR_CMP_CMT: pic_cmp_index = IDX_CMT;
         default: pic_cmp_index = IDX_NONE;
      endcase
   endfunction

   function automatic logic [2:0] pic_target_index(input logic [5:0] addr);
      case (addr)
         ADDR_INT_COND: pic_target_index = IDX_INT_COND;
         ADDR_XMIT: pic_target_index = IDX_XMIT;
         ADDR_RCV_A: pic_target_index = IDX_RCV_A;
         ADDR_RCV_B: pic_target_index = IDX_RCV_B;
         ADDR_CMT: pic_target_index = IDX_CMT;
         default: pic_target_index = IDX_NONE;
      endcase
   endfunction

endpackage

// ==== rtl/pic_cmp_mem.sv ====
// Five-entry store for the compare copies, one write and one read port.
// Read data are registered; contents are not reset.
`timescale 1ns/1ps
module pic_cmp_mem (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic we_i,
   input wire logic [2:0] waddr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [2:0] raddr_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [pic_pkg::CMP_DEPTH];

   always_ff @(posedge core_clk_i) begin
      if (we_i && (waddr_i < 3'(pic_pkg::CMP_DEPTH))) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_o <= 8'h00;
      end else if (raddr_i < 3'(pic_pkg::CMP_DEPTH)) begin
         rdata_o <= mem[raddr_i];
      end else begin
         rdata_o <= 8'h00;
      end
   end
endmodule

// ==== rtl/pic_cond_merge.sv ====
// Merges a conditional write into a register's current value.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ps
module pic_cond_merge (
   input wire logic [7:0] cur_i,
   input wire logic [7:0] cmp_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] merged_o,
   output logic inhibited_o
);
   // Bits that differ from the compare copy the host wrote keep their current value
   wire logic [7:0] stale = cur_i ^ cmp_i;

   assign merged_o = (cur_i & stale) | (wdata_i & ~stale);
   assign inhibited_o = |stale;
endmodule

// ==== rtl/pic_int_cond.sv ====
// Interrupt condition register, compare copies, configuration register
// and interrupt mask, reached over the control bus.
// Assumes every input is synchronous to core_clk_i; event inputs are
// one-cycle pulses; the conditionally written registers of other blocks
// present their current value here and take updates from cond_wr_o.
`timescale 1ns/1ps
module pic_int_cond (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic cb_req_i,
   input wire logic cb_we_i,
   input wire logic [5:0] cb_addr_i,
   input wire logic [7:0] cb_wdata_i,
   output logic cb_ack_o,
   output logic [7:0] cb_rdata_o,
   input wire logic dpe_event_i,
   input wire logic cpe_event_i,
   input wire logic ccr_event_i,
   input wire logic scrub_active_i,
   input wire logic lem_load_i,
   input wire logic [7:0] lem_threshold_i,
   input wire logic lem_error_i,
   input wire logic [7:0] transmit_state_reg_i,
   input wire logic [7:0] receive_condition_reg_a_i,
   input wire logic [7:0] receive_condition_reg_b_i,
   input wire logic [7:0] receive_condition_mask_a_i,
   input wire logic [7:0] receive_condition_mask_b_i,
   input wire logic [7:0] connection_mgmt_condition_reg_i,
   input wire logic [2:0] user_definable_reg_i,
   output pic_pkg::pic_cond_wr_t cond_wr_o,
   output logic [7:0] configuration_reg_o,
   output logic [7:0] interrupt_condition_o,
   output logic int_n_o
);
   pic_pkg::pic_cb_req_t req_q;
   logic req_valid;
   logic [4:0] cond_low;
   logic [7:0] int_mask;
   logic [7:0] lem_count;
   logic [7:0] cmp_rdata;
   logic [7:0] merged;
   logic inhibited;

   // Stage 0: decode the request as it arrives
   wire logic [2:0] in_cmp_idx = pic_pkg::pic_cmp_index(cb_addr_i);
   wire logic [2:0] in_tgt_idx = pic_pkg::pic_target_index(cb_addr_i);
   wire logic in_is_tgt = in_tgt_idx != pic_pkg::IDX_NONE;
   wire logic in_is_cmp = in_cmp_idx != pic_pkg::IDX_NONE;
   wire logic cmp_we = cb_req_i & cb_we_i & in_is_cmp;
   // A target access fetches its compare copy for the next cycle
   wire logic [2:0] cmp_raddr = in_is_tgt ? in_tgt_idx : in_cmp_idx;

   pic_cmp_mem u_cmp_mem (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .we_i(cmp_we),
      .waddr_i(in_cmp_idx),
      .wdata_i(cb_wdata_i),
      .raddr_i(cmp_raddr),
      .rdata_o(cmp_rdata)
   );

   // Stage 1: act on the registered request
   wire logic [2:0] tgt_idx = pic_pkg::pic_target_index(req_q.addr);
   wire logic [2:0] cmp_idx = pic_pkg::pic_cmp_index(req_q.addr);
   wire logic is_tgt = tgt_idx != pic_pkg::IDX_NONE;
   wire logic is_cmp = cmp_idx != pic_pkg::IDX_NONE;
   wire logic wr_stage = req_valid & req_q.we;

   wire logic rcv_a_sum = |(receive_condition_reg_a_i &
                            receive_condition_mask_a_i);
   wire logic rcv_b_sum = |(receive_condition_reg_b_i &
                            receive_condition_mask_b_i);
   wire logic user_sum = |user_definable_reg_i;

   wire logic [7:0] cond_full = {user_sum, rcv_b_sum, rcv_a_sum, cond_low};

   // Current value of whichever conditional register is addressed
   logic [7:0] cur_val;
   always_comb begin
      case (tgt_idx)
         pic_pkg::IDX_INT_COND: cur_val = cond_full;
         pic_pkg::IDX_XMIT: cur_val = transmit_state_reg_i;
         pic_pkg::IDX_RCV_A: cur_val = receive_condition_reg_a_i;
         pic_pkg::IDX_RCV_B: cur_val = receive_condition_reg_b_i;
         pic_pkg::IDX_CMT: cur_val = connection_mgmt_condition_reg_i;
         default: cur_val = 8'h00;
      endcase
   end

   // merge against the fetched compare copy
   pic_cond_merge u_merge (
      .cur_i(cur_val),
      .cmp_i(cmp_rdata),
      .wdata_i(req_q.wdata),
      .merged_o(merged),
      .inhibited_o(inhibited)
   );

   wire logic cond_write = wr_stage & is_tgt;
   wire logic own_write = cond_write & (tgt_idx == pic_pkg::IDX_INT_COND);
   wire logic ext_write = cond_write & (tgt_idx != pic_pkg::IDX_INT_COND);
   wire logic inhibit_set = cond_write & inhibited;
   wire logic cfg_write = wr_stage & (req_q.addr == pic_pkg::ADDR_CONFIG) &
                          ~scrub_active_i;
   wire logic mask_write = wr_stage &
                           (req_q.addr == pic_pkg::ADDR_INT_MASK);

   // flag is set while the counter is at zero
   wire logic link_err_set = lem_count == 8'h00;

   // Sticky low bits: events win over a clearing write in the same cycle
   wire logic [4:0] cond_set = {link_err_set, inhibit_set, ccr_event_i,
                                cpe_event_i, dpe_event_i};
   wire logic [4:0] cond_hold = own_write ? merged[4:0] : cond_low;
   // only a software write lowers the stored bits
   wire logic [4:0] next_cond_low = cond_set | cond_hold;
   wire logic [7:0] next_int_mask = mask_write ? req_q.wdata : int_mask;
   wire logic [7:0] next_cond_full = {user_sum, rcv_b_sum, rcv_a_sum,
                                      next_cond_low};

   // Link error counter: a load wins over a decrement, stops at zero
   wire logic [7:0] next_lem_count =
      lem_load_i ? lem_threshold_i :
      (lem_error_i && lem_count != 8'h00) ? lem_count - 8'h01 : lem_count;

   // Read data for the registered request
   logic [7:0] rd_val;
   always_comb begin
      if (is_tgt) begin
         rd_val = cur_val;
      end else if (is_cmp) begin
         rd_val = cmp_rdata;
      end else if (req_q.addr == pic_pkg::ADDR_CONFIG) begin
         rd_val = configuration_reg_o;
      end else if (req_q.addr == pic_pkg::ADDR_INT_MASK) begin
         rd_val = int_mask;
      end else begin
         rd_val = 8'h00;
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         req_valid <= 1'b0;
         req_q <= '0;
      end else begin
         req_valid <= cb_req_i;
         req_q <= '{we: cb_we_i, addr: cb_addr_i, wdata: cb_wdata_i};
      end
   end

   // counter and flag start at their reset values
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         lem_count <= pic_pkg::LEM_COUNT_RESET;
         cond_low <= pic_pkg::INT_COND_LOW_RESET;
      end else begin
         lem_count <= next_lem_count;
         cond_low <= next_cond_low;
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         int_mask <= pic_pkg::INT_MASK_RESET;
         configuration_reg_o <= pic_pkg::CONFIG_RESET;
      end else begin
         int_mask <= next_int_mask;
         if (cfg_write) begin
            configuration_reg_o <= req_q.wdata;
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cb_ack_o <= 1'b0;
         cb_rdata_o <= 8'h00;
      end else begin
         cb_ack_o <= req_valid;
         cb_rdata_o <= (req_valid & ~req_q.we) ? rd_val : 8'h00;
      end
   end

   // Merged value goes to the owning block, one cycle pulse
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cond_wr_o <= '0;
      end else begin
         cond_wr_o <= '{valid: ext_write, target: tgt_idx, data: merged};
      end
   end

   // active low interrupt, registered on the same edge as the condition byte
   // summaries drop one edge after their sources do
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         int_n_o <= 1'b1;
         interrupt_condition_o <= 8'h00;
      end else begin
         int_n_o <= ~|(next_cond_full & next_int_mask);
         interrupt_condition_o <= next_cond_full;
      end
   end
endmodule

// ==== test/pic_int_cond_asserts.sv ====
// Port checker for the interrupt condition block.
// Assumes one clock, reset_i active high, registered outputs.
`timescale 1ns/1ps
module pic_int_cond_asserts (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic cb_req_i,
   input wire logic cb_we_i,
   input wire logic [5:0] cb_addr_i,
   input wire logic cb_ack_o,
   input wire logic [7:0] cb_rdata_o,
   input wire logic scrub_active_i,
   input wire logic lem_load_i,
   input wire logic [7:0] lem_threshold_i,
   input wire logic [7:0] receive_condition_reg_a_i,
   input wire logic [7:0] receive_condition_reg_b_i,
   input wire logic [7:0] receive_condition_mask_a_i,
   input wire logic [7:0] receive_condition_mask_b_i,
   input wire logic [2:0] user_definable_reg_i,
   input wire pic_pkg::pic_cond_wr_t cond_wr_o,
   input wire logic [7:0] configuration_reg_o,
   input wire logic [7:0] interrupt_condition_o,
   input wire logic int_n_o
);
   wire wr_cond = cb_req_i && cb_we_i && cb_addr_i == pic_pkg::ADDR_INT_COND;
   wire wr_cfg = cb_req_i && cb_we_i && cb_addr_i == pic_pkg::ADDR_CONFIG;
   wire wr_x = cb_req_i && cb_we_i && cb_addr_i == pic_pkg::ADDR_XMIT;
   // Sources of the derived summary bits, sampled one edge back
   wire user_any = |user_definable_reg_i;
   wire rcv_a_any = |(receive_condition_reg_a_i &
      receive_condition_mask_a_i);
   wire rcv_b_any = |(receive_condition_reg_b_i &
      receive_condition_mask_b_i);
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);
   AST_ACK: assert property (cb_req_i |-> ##2 cb_ack_o)
      else $error("no ack after request");
   AST_RDATA_IDLE: assert property (!cb_ack_o |-> cb_rdata_o == 8'h00)
      else $error("read data without ack");
   AST_CFG_LOCK: assert property (
      wr_cfg && scrub_active_i ##1 scrub_active_i && !cb_req_i
      |-> $stable(configuration_reg_o) ##1 $stable(configuration_reg_o))
      else $error("config written while scrubbing");
   AST_INT_PIN: assert property (
      !int_n_o |-> interrupt_condition_o != 8'h00)
      else $error("interrupt pin low with no condition");
   AST_USER_SUM: assert property (!$past(reset_i) |->
      interrupt_condition_o[7] == $past(user_any))
      else $error("user flag differs from sense bits");
   AST_RCV_A_SUM: assert property (!$past(reset_i) |->
      interrupt_condition_o[5] == $past(rcv_a_any))
      else $error("receive A summary wrong");
   AST_RCV_B_SUM: assert property (!$past(reset_i) |->
      interrupt_condition_o[6] == $past(rcv_b_any))
      else $error("receive B summary wrong");
   AST_LINK_ERR: assert property (
      lem_load_i && lem_threshold_i == 8'h00 |=> ##[0:2]
      interrupt_condition_o[4])
      else $error("link error flag not set at zero");
   AST_INHIBIT_STICKY: assert property (
      $fell(interrupt_condition_o[3]) |->
      $past(wr_cond, 1) || $past(wr_cond, 2) || $past(wr_cond, 3))
      else $error("inhibit flag cleared without write");
   AST_CWR_XMIT: assert property (wr_x |-> ##2 cond_wr_o.valid &&
      cond_wr_o.target == pic_pkg::IDX_XMIT)
      else $error("transmit state write not forwarded");
endmodule
bind pic_int_cond pic_int_cond_asserts chk_u (
   .core_clk_i(core_clk_i), .reset_i(reset_i), .cb_req_i(cb_req_i),
   .cb_we_i(cb_we_i), .cb_addr_i(cb_addr_i), .cb_ack_o(cb_ack_o),
   .cb_rdata_o(cb_rdata_o), .scrub_active_i(scrub_active_i),
   .lem_load_i(lem_load_i), .lem_threshold_i(lem_threshold_i),
   .receive_condition_reg_a_i(receive_condition_reg_a_i),
   .receive_condition_reg_b_i(receive_condition_reg_b_i),
   .receive_condition_mask_a_i(receive_condition_mask_a_i),
   .receive_condition_mask_b_i(receive_condition_mask_b_i),
   .user_definable_reg_i(user_definable_reg_i), .cond_wr_o(cond_wr_o),
   .configuration_reg_o(configuration_reg_o),
   .interrupt_condition_o(interrupt_condition_o), .int_n_o(int_n_o));

// ==== test/test_pic_int_cond.sv ====
// Self-checking bench for the interrupt condition block.
// Inputs change on the falling edge; the checker is bound separately.
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
   compares++; \
   if ((g) !== (e)) begin \
      mismatches++; \
      $display("BAD %s exp %h got %h", n, e, g); \
   end \
end
module test_pic_int_cond;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic cb_req_i = 1'b0;
   pic_pkg::pic_cb_req_t bus = '0;
   logic dpe = 1'b0, scrub = 1'b0, lem_load = 1'b0, lem_err = 1'b0;
   logic [7:0] thr = 8'h00, ext = 8'h5a, ma = 8'h00, mb = 8'h00;
   logic [2:0] ud = 3'h0;
   logic ack, int_n;
   logic [7:0] rdata, cfg, cond_byte, rd;
   pic_pkg::pic_cond_wr_t cond_wr, cw;
   int compares = 0;
   int mismatches = 0;
   logic [5:0] ta[4] = '{6'h04, 6'h09, 6'h0a, 6'h20};
   logic [5:0] ca[4] = '{6'h1b, 6'h1c, 6'h1d, 6'h1f};
   // Derived flag cases: masks, sense bits, expected condition byte
   logic [7:0] tm[6] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'ha5};
   logic [7:0] tn[6] = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'ha5};
   logic [2:0] tu[6] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h4, 3'h0};
   logic [7:0] te[6] = '{8'h30, 8'h50, 8'h90, 8'h90, 8'h90, 8'h10};

   pic_int_cond dut_u (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .cb_req_i(cb_req_i),
      .cb_we_i(bus.we), .cb_addr_i(bus.addr), .cb_wdata_i(bus.wdata),
      .cb_ack_o(ack), .cb_rdata_o(rdata), .dpe_event_i(dpe),
      .cpe_event_i(1'b0), .ccr_event_i(1'b0), .scrub_active_i(scrub),
      .lem_load_i(lem_load), .lem_threshold_i(thr), .lem_error_i(lem_err),
      .transmit_state_reg_i(ext), .receive_condition_reg_a_i(ext),
      .receive_condition_reg_b_i(ext), .receive_condition_mask_a_i(ma),
      .receive_condition_mask_b_i(mb),
      .connection_mgmt_condition_reg_i(ext), .user_definable_reg_i(ud),
      .cond_wr_o(cond_wr), .configuration_reg_o(cfg),
      .interrupt_condition_o(cond_byte), .int_n_o(int_n));

   always #5 core_clk_i = ~core_clk_i;

   task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(negedge core_clk_i);
      cb_req_i = 1'b1;
      bus = '{w, a, d};
      @(negedge core_clk_i);
      cb_req_i = 1'b0;
      // Ack, read data and forwarded write appear two edges after request
      @(negedge core_clk_i);
      `CHK("ack", 1'b1, ack)
      rd = rdata;
      cw = cond_wr;
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      `CHK("rdata", e, rd)
   endtask

   // Sources land one cycle late, so allow a margin before looking
   task automatic cond_chk(input logic [7:0] e);
      repeat (3) @(negedge core_clk_i);
      `CHK("cond", e, cond_byte)
   endtask

   task automatic lem(input logic ld, input logic [7:0] t);
      @(negedge core_clk_i);
      thr = t;
      lem_load = ld;
      lem_err = !ld;
      @(negedge core_clk_i);
      lem_load = 1'b0;
      lem_err = 1'b0;
   endtask

   task summarize;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      #50000;
      mismatches++;
      summarize;
   end

   initial begin
      repeat (5) @(negedge core_clk_i);
      reset_i = 1'b0;
      cond_chk(8'h10);
      `CHK("int_n", 1'b1, int_n)
      rd_chk(6'h03, 8'h00);
      rd_chk(6'h01, 8'h00);
      rd_chk(6'h3e, 8'h00);
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, ca[i], 8'h5a);
         rd_chk(ca[i], 8'h5a);
         acc(1'b1, ta[i], 8'h0f);
         `CHK("cond_wr", {1'b1, 3'(i + 1), 8'h0f}, cw)
         acc(1'b1, ca[i], 8'h5b);
         acc(1'b1, ta[i], 8'h0f);
         `CHK("cond_wr", {1'b1, 3'(i + 1), 8'h0e}, cw)
         cond_chk(8'h18);
         cond_chk(8'h18);
         acc(1'b1, 6'h1a, 8'h18);
         rd_chk(6'h1a, 8'h18);
         acc(1'b1, 6'h02, 8'h10);
         cond_chk(8'h10);
      end
      @(negedge core_clk_i);
      dpe = 1'b1;
      @(negedge core_clk_i);
      dpe = 1'b0;
      cond_chk(8'h11);
      acc(1'b1, 6'h02, 8'h10);
      cond_chk(8'h19);
      acc(1'b1, 6'h1a, 8'h19);
      acc(1'b1, 6'h02, 8'h10);
      cond_chk(8'h10);
      scrub = 1'b1;
      acc(1'b1, 6'h01, 8'h3c);
      rd_chk(6'h01, 8'h00);
      scrub = 1'b0;
      acc(1'b1, 6'h01, 8'h3c);
      rd_chk(6'h01, 8'h3c);
      `CHK("cfg", 8'h3c, cfg)
      lem(1'b1, 8'h01);
      acc(1'b1, 6'h1a, 8'h10);
      acc(1'b1, 6'h02, 8'h00);
      cond_chk(8'h00);
      lem(1'b0, 8'h01);
      cond_chk(8'h10);
      lem(1'b1, 8'h00);
      cond_chk(8'h10);
      for (int i = 0; i < 6; i++) begin
         ma = tm[i];
         mb = tn[i];
         ud = tu[i];
         cond_chk(te[i]);
      end
      ma = 8'h02;
      ud = 3'h0;
      cond_chk(8'h30);
      acc(1'b1, 6'h1a, 8'h30);
      acc(1'b1, 6'h02, 8'hd0);
      cond_chk(8'h30);
      acc(1'b1, 6'h03, 8'h20);
      rd_chk(6'h03, 8'h20);
      cond_chk(8'h30);
      `CHK("int_n", 1'b0, int_n)
      ma = 8'h00;
      cond_chk(8'h10);
      `CHK("int_n", 1'b1, int_n)
      summarize;
   end
endmodule
